/* File: verilog/apl_pkg.sv */
// Constants of the axis position latch
// Operation
// R1: Host sets and sends custom bit 04 before latch use.
// R2: Table first address above 1996 is out of range.
// R3: Function word must be 4; above 4 is out of range.
// R4: Trigger 1 is general input rise, 2 phase-Z rise.
// R5: Phase Z of latch axis, or general input 1 to 4 for X to U.
// R6: Third word: destination address, 0 to 1999.
// R7: Status 0 at command, 1 at capture.
// R8: Bad operand is out of range; status word unchecked.
// R9: Trigger edge stores axis position at destination.
// R10: Command only arms; next block follows at once.
// R11: Armed latch captures even while halted.
// R12: Latch ends on capture, program end, or restart.
// R13: Same axis and trigger rearm replaces old; edges may drop.
// R14: Latch input not shared with other input functions.
// R15: Mode commands advance whatever mode while armed.
// R16: Move without table reference is plain interpolation.
// R17: Gear/cam cancel does not cancel an armed latch.
// R18: Inputs synchronised; each rise caught once.
package apl_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_AXES = 4;
    localparam int NUM_SLOTS = 8;
    localparam int POS_W = 32;
    localparam int MEM_DEPTH = 2000;
    localparam int MEM_AW = 11;
    localparam int OPD_W = 16;

    // ------------------------------------------------------------
    // Operand values and limits
    // ------------------------------------------------------------
    localparam logic [OPD_W-1:0] FUNC_LATCH = 16'h0004;
    localparam logic [OPD_W-1:0] COND_GP = 16'h0001;
    localparam logic [OPD_W-1:0] COND_PHZ = 16'h0002;
    localparam logic [OPD_W-1:0] TABLE_ADDR_MAX = 16'h07cc;
    localparam logic [OPD_W-1:0] POS_ADDR_MAX = 16'h07cf;
    localparam logic [OPD_W-1:0] STATUS_OFS = 16'h0003;
    localparam logic [OPD_W-1:0] STATUS_WAIT = 16'h0000;
    localparam logic [OPD_W-1:0] STATUS_DONE = 16'h0001;
    localparam int CUSTOM_EN_BIT = 4;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ARMED = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_MEM_ADDR = 8'h10;
    localparam logic [7:0] REG_MEM_DATA = 8'h14;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
    localparam int IRQ_ERR_BIT = 8;
    localparam int IRQ_W = 9;
endpackage

/* File: verilog/apl_mem_if.sv */
// Interface from latch control to position memory
`timescale 1ns/10ps
interface apl_mem_if #(
    parameter int AW = 11,
    parameter int DW = 32
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
        output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
        input rd_addr, output rd_data);
endinterface

/* File: verilog/apl_edge_sync.sv */
// Three-stage synchroniser, rising edge pulse on agreed level
`timescale 1ns/10ps
module apl_edge_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Raw pins and edge pulses
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_rise
);
    if (WIDTH < 1) begin : g_chk
        $error("apl_edge_sync: WIDTH must be at least 1");
    end

    // ------------------------------------------------------------
    // One synchroniser per input bit
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1_reg, s2_reg, s3_reg, level_reg, rise_reg;

        // Only stage two reads stage one, containing metastability
        always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
            end else begin
                s1_reg <= i_pin[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
            end
        end

        // Level moves only when stages two and three agree
        always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                level_reg <= 1'b0;
                rise_reg <= 1'b0;
            end else begin
                if (s2_reg == s3_reg) begin
                    level_reg <= s2_reg;
                end
                rise_reg <= (s2_reg == s3_reg) && s2_reg && !level_reg; // R18
            end
        end

        assign o_rise[i] = rise_reg;
    end
endmodule

/* File: verilog/apl_pos_mem.sv */
// Position data memory with registered read
`timescale 1ns/10ps
module apl_pos_mem #(
    parameter int DEPTH = 2000
) (
    // Clock
    input wire logic i_clock,
    // Access port
    apl_mem_if.mem mem
);
    if (DEPTH > (1 << $bits(mem.wr_addr))) begin : g_chk
        $error("apl_pos_mem: DEPTH exceeds address range");
    end

    logic [$bits(mem.wr_data)-1:0] ram [DEPTH];

    // Write port; out-of-range addresses are dropped
    always_ff @(posedge i_clock) begin
        if (mem.wr_en && (int'(mem.wr_addr) < DEPTH)) begin
            ram[mem.wr_addr] <= mem.wr_data;
        end
    end

    // Registered read data
    always_ff @(posedge i_clock) begin
        if (int'(mem.rd_addr) < DEPTH) begin
            mem.rd_data <= ram[mem.rd_addr];
        end else begin
            mem.rd_data <= '0;
        end
    end
endmodule

/* File: verilog/apl_position_latch.sv */
// Axis position latch: arming, capture, store and register bus
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module apl_position_latch #(
    parameter int NUM_AXES = apl_pkg::NUM_AXES,
    parameter int POS_W = apl_pkg::POS_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Interrupt
    output logic o_irq,
    // Latch command from the program sequencer
    input wire logic i_cmd_valid,
    input wire logic i_cmd_table_ref,
    input wire logic [1:0] i_cmd_axis,
    input wire logic [15:0] i_cmd_table_addr,
    input wire logic [15:0] i_cmd_func,
    input wire logic [15:0] i_cmd_cond,
    input wire logic [15:0] i_cmd_dest,
    output logic o_cmd_done,
    output logic o_cmd_error,
    output logic o_linear_move,
    // Mode commands and program events
    input wire logic i_mode_cmd_valid,
    output logic o_mode_cmd_done,
    input wire logic i_program_end_done,
    input wire logic i_program_restart,
    input wire logic i_program_halted,
    input wire logic i_gear_cam_cancel,
    // Status word write towards the operand table
    output logic o_stat_wr,
    output logic [15:0] o_stat_addr,
    output logic [15:0] o_stat_data,
    // Encoder positions and trigger pins
    input wire logic [NUM_AXES*POS_W-1:0] i_position,
    input wire logic [NUM_AXES-1:0] i_gp_in,
    input wire logic [NUM_AXES-1:0] i_phase_z
);
    localparam int NSLOT = 2 * NUM_AXES;

    if (NUM_AXES != apl_pkg::NUM_AXES || POS_W < 1 || POS_W > 32)
    begin : g_chk
        $error("apl_position_latch: unsupported NUM_AXES or POS_W");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] mask_reg;
    logic [apl_pkg::MEM_AW-1:0] mem_addr_reg;
    logic [apl_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [NSLOT-1:0] armed_reg;
    logic [NSLOT-1:0] pend_reg;
    logic [apl_pkg::MEM_AW-1:0] dest_reg [NSLOT];
    logic [15:0] tbl_reg [NSLOT];
    logic [POS_W-1:0] cap_reg [NSLOT];
    logic [NUM_AXES-1:0] gp_rise, phz_rise;
    logic [NSLOT-1:0] trig;
    logic cmd_ok, cmd_bad, cmd_arm;
    logic [2:0] cmd_slot;
    logic grant_any;
    logic [2:0] grant_slot;
    logic [NSLOT-1:0] done_set;
    logic bus_req, bus_acc, rd_stat;
    logic [31:0] mem_addr_next;

    apl_mem_if #(.AW(apl_pkg::MEM_AW), .DW(POS_W)) mem_bus ();

    // ------------------------------------------------------------
    // Trigger inputs and position memory
    // ------------------------------------------------------------
    // One synchroniser bank for both pin groups
    apl_edge_sync #(.WIDTH(2 * NUM_AXES)) u_sync (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_pin({i_phase_z, i_gp_in}),
        .o_rise({phz_rise, gp_rise})
    );

    apl_pos_mem #(.DEPTH(apl_pkg::MEM_DEPTH)) u_mem (
        .i_clock(i_clock),
        .mem(mem_bus.mem)
    );

    // ------------------------------------------------------------
    // Command check
    // ------------------------------------------------------------
    // Slot is axis*2 plus trigger kind; phase Z is odd
    assign cmd_slot = {i_cmd_axis, i_cmd_cond == apl_pkg::COND_PHZ};
    // Only a table-reference move arms
    assign cmd_arm = i_cmd_valid && i_cmd_table_ref; // R16
    // Status word is exempt from range checks
    assign cmd_ok = ctrl_reg[apl_pkg::CUSTOM_EN_BIT]
        && (i_cmd_table_addr <= apl_pkg::TABLE_ADDR_MAX) // R2
        && (i_cmd_func == apl_pkg::FUNC_LATCH) // R3 R8
        && (i_cmd_cond == apl_pkg::COND_GP
            || i_cmd_cond == apl_pkg::COND_PHZ) // R4 R8
        && (i_cmd_dest <= apl_pkg::POS_ADDR_MAX); // R6 R8
    assign cmd_bad = cmd_arm && !cmd_ok;

    // Answer next cycle, never waiting for capture
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cmd_done <= 1'b0;
            o_cmd_error <= 1'b0;
            o_linear_move <= 1'b0;
            o_mode_cmd_done <= 1'b0;
        end else begin
            o_cmd_done <= i_cmd_valid; // R10
            o_cmd_error <= cmd_bad; // R8
            o_linear_move <= i_cmd_valid && !i_cmd_table_ref; // R16
            o_mode_cmd_done <= i_mode_cmd_valid; // R15
        end
    end

    // ------------------------------------------------------------
    // Trigger routing per slot
    // ------------------------------------------------------------
    // Even slot: general input; odd slot: phase Z
    for (genvar s = 0; s < NSLOT; s++) begin : g_trig
        assign trig[s] = (s % 2 == 1) ? phz_rise[s/2] : gp_rise[s/2]; // R5
    end

    // ------------------------------------------------------------
    // Arming, capture and termination per slot
    // ------------------------------------------------------------
    // Halt and gear/cam cancel are unused on purpose
    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        logic new_cmd;
        assign new_cmd = cmd_arm && cmd_ok && (cmd_slot == 3'(s));

        // New command wins over a same-cycle edge
        always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                armed_reg[s] <= 1'b0;
            end else if (new_cmd) begin
                armed_reg[s] <= 1'b1; // R13
            end else if (i_program_end_done || i_program_restart) begin
                armed_reg[s] <= 1'b0; // R12
            end else if (armed_reg[s] && trig[s]) begin
                armed_reg[s] <= 1'b0; // R12
            end
        end

        // Capture on the edge, store later
        always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                pend_reg[s] <= 1'b0;
                cap_reg[s] <= '0;
            end else if (new_cmd) begin
                pend_reg[s] <= 1'b0; // R13
            end else if (armed_reg[s] && trig[s]) begin
                pend_reg[s] <= 1'b1; // R9 R11 R17
                cap_reg[s] <= i_position[(s/2)*POS_W +: POS_W]; // R9
            end else if (done_set[s]) begin
                pend_reg[s] <= 1'b0;
            end
        end

        // Operands kept for store and status
        always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                dest_reg[s] <= '0;
                tbl_reg[s] <= '0;
            end else if (new_cmd) begin
                dest_reg[s] <= i_cmd_dest[apl_pkg::MEM_AW-1:0]; // R6
                tbl_reg[s] <= i_cmd_table_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Store arbitration
    // ------------------------------------------------------------
    // One port: lowest pending slot first, others wait.
    // A command status write wins, so stores stall.
    always_comb begin
        grant_any = 1'b0;
        grant_slot = '0;
        done_set = '0;
        for (int k = NSLOT - 1; k >= 0; k--) begin
            if (pend_reg[k]) begin
                grant_any = 1'b1;
                grant_slot = 3'(k);
            end
        end
        if (cmd_arm && cmd_ok) begin
            grant_any = 1'b0;
        end
        if (grant_any) begin
            done_set[grant_slot] = 1'b1;
        end
    end

    assign mem_bus.wr_en = grant_any; // R9
    assign mem_bus.wr_addr = dest_reg[grant_slot];
    assign mem_bus.wr_data = cap_reg[grant_slot];
    assign mem_bus.rd_addr = mem_addr_reg;

    // Status word: 0 at arming, 1 at store
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stat_wr <= 1'b0;
            o_stat_addr <= '0;
            o_stat_data <= '0;
        end else if (cmd_arm && cmd_ok) begin
            o_stat_wr <= 1'b1;
            o_stat_addr <= i_cmd_table_addr + apl_pkg::STATUS_OFS;
            o_stat_data <= apl_pkg::STATUS_WAIT; // R7
        end else if (grant_any) begin
            o_stat_wr <= 1'b1;
            o_stat_addr <= tbl_reg[grant_slot] + apl_pkg::STATUS_OFS;
            o_stat_data <= apl_pkg::STATUS_DONE; // R7
        end else begin
            o_stat_wr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign bus_req = i_wb_cyc && i_wb_stb;
    // Effect lands on the edge that sees ack
    assign bus_acc = bus_req && o_wb_ack;
    assign rd_stat = bus_acc && !i_wb_we
        && (i_wb_adr == apl_pkg::REG_IRQ_STAT);

    // Byte-lane merge and merged address write value
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction
    assign mem_addr_next = lane_merge(32'(mem_addr_reg), i_wb_dat, i_wb_sel);

    // Ack one cycle after request, one cycle long
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= bus_req && !o_wb_ack;
        end
    end

    // Registered read mux; unmapped reads give zero
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wb_dat <= '0;
        end else if (bus_req && !o_wb_ack) begin
            case (i_wb_adr)
                apl_pkg::REG_CTRL: o_wb_dat <= ctrl_reg;
                apl_pkg::REG_ARMED: o_wb_dat <= 32'(armed_reg);
                apl_pkg::REG_IRQ_STAT: o_wb_dat <= 32'(irq_stat_reg);
                apl_pkg::REG_IRQ_MASK: o_wb_dat <= mask_reg;
                apl_pkg::REG_MEM_ADDR: o_wb_dat <= 32'(mem_addr_reg);
                apl_pkg::REG_MEM_DATA: o_wb_dat <= 32'(mem_bus.rd_data);
                default: o_wb_dat <= '0;
            endcase
        end
    end

    // Writable registers; CTRL bit 4 gates arming
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= apl_pkg::CTRL_RST;
            mask_reg <= apl_pkg::IRQ_MASK_RST;
            mem_addr_reg <= '0;
        end else if (bus_acc && i_wb_we) begin
            case (i_wb_adr)
                apl_pkg::REG_CTRL:
                    ctrl_reg <= lane_merge(ctrl_reg, i_wb_dat, i_wb_sel); // R1
                apl_pkg::REG_IRQ_MASK: begin
                    mask_reg <= 32'(lane_merge(mask_reg, i_wb_dat,
                        i_wb_sel) & 32'h0000_01ff);
                end
                apl_pkg::REG_MEM_ADDR:
                    mem_addr_reg <= mem_addr_next[apl_pkg::MEM_AW-1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    // Sticky bits: read clears, a same-cycle event stays
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg)
                | {cmd_bad, done_set};
        end
    end

    assign o_irq = |(irq_stat_reg & mask_reg[apl_pkg::IRQ_W-1:0]);
endmodule

/* File: tb/apl_position_latch_props.sv */
// Port checker for the axis position latch
`timescale 1ns/10ps
module apl_position_latch_props (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Command
    input wire logic i_cmd_valid,
    input wire logic i_cmd_table_ref,
    input wire logic [15:0] i_cmd_table_addr,
    input wire logic [15:0] i_cmd_func,
    input wire logic [15:0] i_cmd_cond,
    input wire logic [15:0] i_cmd_dest,
    input wire logic i_mode_cmd_valid,
    // Answers
    input wire logic o_cmd_done,
    input wire logic o_cmd_error,
    input wire logic o_linear_move,
    input wire logic o_mode_cmd_done,
    input wire logic o_stat_wr,
    input wire logic [15:0] o_stat_addr,
    input wire logic [15:0] o_stat_data
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    // Table command; one with all operands legal
    logic tcmd;
    logic ok_ops;
    assign tcmd = i_cmd_valid && i_cmd_table_ref;
    assign ok_ops = tcmd && i_cmd_func == 16'h4 && i_cmd_table_addr <= 16'h07cc
        && (i_cmd_cond == 16'h1 || i_cmd_cond == 16'h2)
        && i_cmd_dest <= 16'h07cf;

    property p_done; i_cmd_valid |=> o_cmd_done; endproperty
    a_done: assert property (p_done) else $error("no advance");
    property p_errd; o_cmd_error |-> o_cmd_done; endproperty
    a_errd: assert property (p_errd) else $error("lone error");
    property p_lin; i_cmd_valid && !i_cmd_table_ref |=> o_linear_move;
    endproperty
    a_lin: assert property (p_lin) else $error("no move");
    property p_nolin; tcmd |=> !o_linear_move; endproperty
    a_nolin: assert property (p_nolin) else $error("moved");
    property p_tab; tcmd && i_cmd_table_addr > 16'h07cc |=> o_cmd_error;
    endproperty
    a_tab: assert property (p_tab) else $error("table addr");
    property p_func; tcmd && i_cmd_func > 16'h4 |=> o_cmd_error; endproperty
    a_func: assert property (p_func) else $error("func");
    property p_rng;
        tcmd && (i_cmd_dest > 16'h07cf || i_cmd_cond == 16'h0
            || i_cmd_cond > 16'h2) |=> o_cmd_error;
    endproperty
    a_rng: assert property (p_rng) else $error("range");
    property p_stat;
        ok_ops |=> o_cmd_error || (o_stat_wr && o_stat_data == 16'h0
            && o_stat_addr == $past(i_cmd_table_addr) + 16'h3);
    endproperty
    a_stat: assert property (p_stat) else $error("wait status");
    property p_mode; i_mode_cmd_valid |=> o_mode_cmd_done; endproperty
    a_mode: assert property (p_mode) else $error("mode stall");
endmodule

bind apl_position_latch apl_position_latch_props u_props (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid),
    .i_cmd_table_ref(i_cmd_table_ref), .i_cmd_table_addr(i_cmd_table_addr),
    .i_cmd_func(i_cmd_func), .i_cmd_cond(i_cmd_cond),
    .i_cmd_dest(i_cmd_dest), .i_mode_cmd_valid(i_mode_cmd_valid),
    .o_cmd_done(o_cmd_done), .o_cmd_error(o_cmd_error),
    .o_linear_move(o_linear_move), .o_mode_cmd_done(o_mode_cmd_done),
    .o_stat_wr(o_stat_wr), .o_stat_addr(o_stat_addr),
    .o_stat_data(o_stat_data));

/* File: tb/apl_enc_model.sv */
// Encoder counters and trigger pins in front of the latch
`timescale 1ns/10ps
module apl_enc_model (
    // Clock, reset, count enable
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_run,
    // Requested pin levels
    input wire logic [3:0] i_gp,
    input wire logic [3:0] i_z,
    // Towards the latch
    output logic [127:0] o_position,
    output logic [3:0] o_gp_in,
    output logic [3:0] o_phase_z
);
    // Distinct speeds per axis expose a wrong axis
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_position <= 128'h0;
        end else if (i_run) begin
            for (int a = 0; a < 4; a++) begin
                o_position[a*32 +: 32] <= o_position[a*32 +: 32] + 32'(a+7);
            end
        end
    end
    // Pins serve the latch alone, no other input function
    assign o_gp_in = i_gp;
    assign o_phase_z = i_z;
endmodule

/* File: tb/apl_position_latch_tb.sv */
// Self-checking bench of the axis position latch
`timescale 1ns/10ps
module apl_position_latch_tb;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic cv = 1'b0, tref = 1'b0, mv = 1'b0, pend = 1'b0, prst = 1'b0;
    logic halt = 1'b0, gcc = 1'b0, run = 1'b1, en = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, wdo;
    logic [1:0] ax = 2'h0;
    logic [15:0] ta = 16'h0, fn = 16'h0, cd = 16'h0, ds = 16'h0, sa, sdat;
    logic [3:0] gp = 4'h0, pz = 4'h0, gpw, pzw;
    logic ack, irq, done, err, lin, mdone, swr;
    logic [127:0] pos;
    logic [15:0] tv [6][4];
    int errors = 0, tests_run = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    apl_position_latch dut (.i_clock(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
        .i_wb_dat(wd), .o_wb_dat(wdo), .o_wb_ack(ack), .o_irq(irq),
        .i_cmd_valid(cv), .i_cmd_table_ref(tref), .i_cmd_axis(ax),
        .i_cmd_table_addr(ta), .i_cmd_func(fn), .i_cmd_cond(cd),
        .i_cmd_dest(ds), .o_cmd_done(done), .o_cmd_error(err),
        .o_linear_move(lin), .i_mode_cmd_valid(mv), .o_mode_cmd_done(mdone),
        .i_program_end_done(pend), .i_program_restart(prst),
        .i_program_halted(halt), .i_gear_cam_cancel(gcc), .o_stat_wr(swr),
        .o_stat_addr(sa), .o_stat_data(sdat), .i_position(pos),
        .i_gp_in(gpw), .i_phase_z(pzw));
    apl_enc_model u_enc (.i_clock(clk), .i_rst_b(rst_b), .i_run(run),
        .i_gp(gp), .i_z(pz), .o_position(pos), .o_gp_in(gpw),
        .o_phase_z(pzw));

    // Compare and count
    task chk(input logic [39:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task tally_and_finish();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task tout();
        errors++;
        tally_and_finish();
    endtask
    // Expected refusal
    function automatic logic exp_err(input logic [15:0] t, f, c, d);
        return !en || t > 16'h07cc || f != 16'h4 || d > 16'h07cf
            || (c != 16'h1 && c != 16'h2);
    endfunction
    // Classic Wishbone cycle, held until ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb} <= 2'b11;
        we <= w;
        adr <= a;
        wd <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = wdo;
        {cyc, stb} <= 2'b00;
        if (n >= 40) tout();
    endtask
    // One sequencer command, answer next cycle
    task cmd(input logic r, input logic [1:0] a, input logic [15:0] t, f, c,
        d);
        @(posedge clk);
        cv <= 1'b1;
        tref <= r;
        ax <= a;
        ta <= t;
        fn <= f;
        cd <= c;
        ds <= d;
        @(posedge clk);
        cv <= 1'b0;
        @(posedge clk);
        chk(done, 1'b1, "done");
        chk(lin, !r, "move");
        if (r) chk(err, exp_err(t, f, c, d), "error");
        if (r && !exp_err(t, f, c, d)) chk({swr, sa, sdat},
            {1'b1, t + 16'h3, 16'h0}, "wait status");
    endtask
    // Arm, wrong trigger, right trigger, read back
    task cap(input logic [1:0] a, input logic [15:0] c, t, d);
        logic [31:0] p;
        int n;
        int sl;
        sl = a * 2 + (c == 16'h2);
        cmd(1'b1, a, t, 16'h4, c, d);
        run <= 1'b0;
        if (c == 16'h2) gp[a] <= 1'b1;
        else pz[a] <= 1'b1;
        repeat (8) @(posedge clk);
        wb(1'b0, apl_pkg::REG_ARMED, 32'h0);
        chk(rd, 32'h1 << sl, "armed");
        p = pos[a*32 +: 32];
        if (c == 16'h2) pz[a] <= 1'b1;
        else gp[a] <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(swr === 1'b1 && sdat === 16'h1) && n < 40);
        if (n >= 40) tout();
        chk(sa, t + 16'h3, "done status");
        gp <= 4'h0;
        pz <= 4'h0;
        run <= 1'b1;
        chk(irq, 1'b1, "irq");
        wb(1'b0, apl_pkg::REG_IRQ_STAT, 32'h0);
        chk(rd, 32'h1 << sl, "event");
        @(posedge clk);
        chk(irq, 1'b0, "irq clear");
        wb(1'b1, apl_pkg::REG_MEM_ADDR, {16'h0, d});
        @(posedge clk);
        wb(1'b0, apl_pkg::REG_MEM_DATA, 32'h0);
        chk(rd, p, "position");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int k;
        k = $urandom(32'h0fa8);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wb(1'b0, apl_pkg::REG_CTRL, 32'h0);
        chk(rd, apl_pkg::CTRL_RST, "ctrl");
        wb(1'b0, apl_pkg::REG_IRQ_MASK, 32'h0);
        chk(rd, apl_pkg::IRQ_MASK_RST, "mask");
        wb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0, "unmapped");
        cmd(1'b1, 2'h0, 16'h0, 16'h4, 16'h1, 16'h0);
        wb(1'b1, apl_pkg::REG_CTRL, 32'h10);
        en = 1'b1;
        cmd(1'b0, 2'h1, 16'h0, 16'h0, 16'h0, 16'h0);
        // Range edges; the last row is legal, arms slot 1
        tv = '{'{16'h07cd, 16'h4, 16'h1, 16'h0}, '{16'h0, 16'h5, 16'h1, 16'h0},
            '{16'h0, 16'h3, 16'h2, 16'h0}, '{16'h0, 16'h4, 16'h3, 16'h0},
            '{16'h0, 16'h4, 16'h0, 16'h07d0},
            '{16'h07cc, 16'h4, 16'h2, 16'h07cf}};
        for (k = 0; k < 6; k++) begin
            cmd(1'b1, 2'h0, tv[k][0], tv[k][1], tv[k][2], tv[k][3]);
        end
        chk(irq, 1'b0, "masked");
        wb(1'b0, apl_pkg::REG_IRQ_STAT, 32'h0);
        chk(rd, 32'h100, "error event");
        wb(1'b0, apl_pkg::REG_IRQ_STAT, 32'h0);
        chk(rd, 32'h0, "read clear");
        // Restart, then program end, each disarm
        prst <= 1'b1;
        wb(1'b0, apl_pkg::REG_ARMED, 32'h0);
        prst <= 1'b0;
        chk(rd, 32'h0, "restart");
        cmd(1'b1, 2'h3, 16'h14, 16'h4, 16'h2, 16'h7);
        pend <= 1'b1;
        wb(1'b0, apl_pkg::REG_ARMED, 32'h0);
        pend <= 1'b0;
        chk(rd, 32'h0, "end");
        wb(1'b1, apl_pkg::REG_IRQ_MASK, 32'h1ff);
        // Same slot armed twice; later destination wins
        cmd(1'b1, 2'h2, 16'h30, 16'h4, 16'h1, 16'h64);
        cap(2'h2, 16'h1, 16'h40, 16'h0c8);
        halt <= 1'b1;
        gcc <= 1'b1;
        for (k = 0; k < 6; k++) begin
            cap(2'($urandom_range(3)), 16'($urandom_range(2, 1)),
                16'($urandom_range(1996)), 16'($urandom_range(1999)));
        end
        mv <= 1'b1;
        @(posedge clk);
        mv <= 1'b0;
        @(posedge clk);
        chk(mdone, 1'b1, "mode");
        tally_and_finish();
    end
endmodule
